// File: src/bcxd_core.sv
/*
 * Transfer-descriptor store and transfer sequencer of a command/response
 * bus controller, with an APB register slave.
 * Assumes a bus interface processor that encodes words on the bus and
 * returns one answer per accepted request.
 */
`timescale 1ns/1ns
module bcxd_core
    import bcxd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic link_req_valid,
    input wire logic link_req_ready,
    output bcxd_req_t link_req,
    input wire logic link_rsp_valid,
    input wire bcxd_rsp_word_t link_rsp,
    output logic host_event
);

    function automatic logic is_mode(input logic [4:0] sa);
        is_mode = (sa == SA_MODE_LO) || (sa == SA_MODE_HI);
    endfunction

    function automatic logic [15:0] cmd_word(input logic [4:0] rt, input logic tx, input logic [4:0] sa,
                                             input logic [4:0] wc);
        cmd_word = {rt, tx, sa, wc};
    endfunction

    function automatic logic [QIDX_W-1:0] qsize(input bcxd_hdr_t h);
        qsize = QIDX_W'(1) << h.h0.qsize_code;
    endfunction

    function automatic logic [BUF_W-1:0] pool_idx(input bcxd_hdr_t h);
        pool_idx = h.h0.first_buf + BUF_W'(h.h1.cur_idx);
    endfunction

    function automatic logic [QIDX_W-1:0] next_idx(input bcxd_hdr_t h, input logic err);
        logic [QIDX_W-1:0] nxt;
        nxt = h.h1.cur_idx + QIDX_W'(1);
        if (err && h.h0.store_keep) begin
            next_idx = h.h1.cur_idx;
        end else if (!h.h0.queue_wraparound) begin
            next_idx = h.h1.cur_idx;
        end else if (nxt >= qsize(h)) begin
            next_idx = '0;
        end else begin
            next_idx = nxt;
        end
    endfunction

    function automatic bcxd_req_t build_req(input bcxd_desc_t d, input logic bus, input logic [BUF_W-1:0] bi);
        bcxd_req_t r;
        r = '0;
        case (d.w0.dir)
            DIR_RT_BC: begin
                r.cmd1 = cmd_word(d.w0.transmitting_terminal, 1'b1, d.w0.transmit_subaddress, d.w0.wcnt);
                r.expect_sw1 = 1'b1;
            end
            DIR_RT_RT: begin
                r.cmd1 = cmd_word(d.w0.receiving_terminal, 1'b0, d.w0.receive_subaddress, d.w0.wcnt);
                r.cmd2 = cmd_word(d.w0.transmitting_terminal, 1'b1, d.w0.transmit_subaddress, d.w0.wcnt);
                r.two_cmd = 1'b1;
                r.expect_sw1 = 1'b1;
                r.expect_sw2 = 1'b1;
            end
            default: begin
                r.cmd1 = cmd_word(d.w0.receiving_terminal, 1'b0, d.w0.receive_subaddress, d.w0.wcnt);
                r.expect_sw1 = 1'b1;
            end
        endcase
        // word count field as mode code
        r.mode = is_mode(d.w0.transmit_subaddress) && d.w0.dir != DIR_BC_RT
              || is_mode(d.w0.receive_subaddress) && d.w0.dir != DIR_RT_BC;
        if (d.w0.rsp == RSP_NO_SW1) begin
            r.expect_sw1 = 1'b0;
        end
        if (d.w0.rsp == RSP_NO_SW2) begin
            r.expect_sw2 = 1'b0;
        end
        r.bus = bus;
        // buffer always present even for no data
        r.buf_idx = bi;
        r.err_type = (d.w1.err_type > ERR_LAST) ? ERR_NONE : d.w1.err_type;
        // sync pattern only for sync schemes
        if (d.w1.err_type == ERR_CMD_SYNC || d.w1.err_type == ERR_DATA_SYNC) begin
            r.err_sync = d.w1.err_sync;
        end
        build_req = r;
    endfunction

    bcxd_state_t st;
    bcxd_state_t next_st;
    bcxd_desc_t cd;
    bcxd_hdr_t ch;
    logic wr_commit;
    logic rd_first;
    logic rsp_err;
    logic sxw;
    logic irq_fire;
    logic halt_fire;
    logic srq_go;
    logic start_go;
    logic [GAP_W-1:0] gap_cyc;
    bcxd_status_t stat;
    bcxd_dw0_t w0;
    bcxd_dw1_t w1;
    bcxd_dw2_t w2;
    bcxd_hw0_t hw0;
    bcxd_hw1_t hw1;

    assign cd = st.desc[st.xid];
    assign ch = st.hdr[cd.w1.hdr_id];
    assign wr_commit = psel && penable && pwrite && st.ack;
    assign rd_first = psel && penable && !st.ack;

    always_comb begin
        stat = '0;
        stat.last_xid = st.xid;
        stat.halted = st.halted;
        stat.busy = st.fsm != S_IDLE;
        {stat.sxw, stat.err, stat.eot} = st.evt;
    end

    always_comb begin
        rsp_err = link_rsp.err;
        if (st.req.expect_sw1 != link_rsp.sw1_seen) begin
            rsp_err = 1'b1;
        end
        if (st.req.two_cmd && st.req.expect_sw2 != link_rsp.sw2_seen) begin
            rsp_err = 1'b1;
        end
    end

    assign sxw = |(((link_rsp.sw1_seen ? link_rsp.sw1[SW_CHECK_W-1:0] : '0)
                  | (link_rsp.sw2_seen ? link_rsp.sw2[SW_CHECK_W-1:0] : '0)) & cd.w2.swxm);

    always_comb begin
        case (cd.w1.irq_sel)
            IRQ_EOT: irq_fire = 1'b1;
            IRQ_ERR: irq_fire = rsp_err;
            IRQ_SXW: irq_fire = sxw;
            default: irq_fire = 1'b0;
        endcase
    end

    always_comb begin
        case (cd.w1.halt_sel)
            HLT_EOT: halt_fire = 1'b1;
            HLT_ERR: halt_fire = rsp_err;
            HLT_SXW: halt_fire = sxw;
            HLT_ANY_INT: halt_fire = irq_fire;
            default: halt_fire = 1'b0;
        endcase
    end

    // vector word request on service request bit
    assign srq_go = st.srq_en && cd.w1.srq_act != 2'h0 && !rsp_err && link_rsp.sw1_seen && link_rsp.sw1[SRQ_BIT];

    always_comb begin
        gap_cyc = GAP_W'(cd.w2.gap) * GAP_W'(CYC_PER_US);
        if (!cd.w1.gap_mode && gap_cyc < GAP_W'(MIN_GAP_CYC)) begin
            gap_cyc = GAP_W'(MIN_GAP_CYC);
        end else if (gap_cyc == '0) begin
            gap_cyc = GAP_W'(1);
        end
    end

    // any id up to the last one is accepted
    assign start_go = wr_commit && paddr == A_START && pwdata[XID_W-1:0] <= LAST_XID
                   && st.fsm == S_IDLE && !st.halted;

    always_comb begin
        next_st = st;
        next_st.host_event = 1'b0;
        next_st.ack = rd_first;
        w0 = bcxd_dw0_t'(pwdata);
        w1 = bcxd_dw1_t'(pwdata);
        w1.rsvd = '0;
        w2 = bcxd_dw2_t'(pwdata);
        w2.rsvd = '0;
        hw0 = bcxd_hw0_t'(pwdata);
        hw0.rsvd = '0;
        hw1 = bcxd_hw1_t'(pwdata);
        hw1.rsvd = '0;
        if (rd_first) begin
            next_st.perr = 1'b0;
            next_st.prdata = '0;
            case (paddr)
                A_CTRL: next_st.prdata = 32'(st.srq_en);
                A_START: next_st.prdata = 32'(st.xid);
                A_STATUS: next_st.prdata = stat;
                A_DSEL: next_st.prdata = 32'(st.dsel);
                A_DESC0: next_st.prdata = st.desc[st.dsel].w0;
                A_DESC1: next_st.prdata = st.desc[st.dsel].w1;
                A_DESC2: next_st.prdata = st.desc[st.dsel].w2;
                A_HSEL: next_st.prdata = 32'(st.hsel);
                A_HDR0: next_st.prdata = st.hdr[st.hsel].h0;
                A_HDR1: next_st.prdata = st.hdr[st.hsel].h1;
                A_LAST_SW: next_st.prdata = 32'(st.last_sw);
                A_VECTOR: next_st.prdata = 32'(st.vector);
                default: next_st.perr = 1'b1;
            endcase
            if (paddr == A_DSEL && pwrite && pwdata[XID_W-1:0] > LAST_XID) begin
                next_st.perr = 1'b1;
            end
        end
        if (wr_commit && !st.perr) begin
            case (paddr)
                A_CTRL: next_st.srq_en = pwdata[0];
                A_STATUS: begin
                    next_st.evt = st.evt & ~pwdata[2:0];
                    if (pwdata[4]) begin
                        next_st.halted = 1'b0;
                    end
                end
                A_DSEL: next_st.dsel = pwdata[XID_W-1:0];
                // no sharing check on buffer assignment
                A_DESC0: next_st.desc[st.dsel].w0 = w0;
                A_DESC1: next_st.desc[st.dsel].w1 = w1;
                A_DESC2: next_st.desc[st.dsel].w2 = w2;
                A_HSEL: next_st.hsel = pwdata[HID_W-1:0];
                // header changes accepted at any time
                A_HDR0: next_st.hdr[st.hsel].h0 = hw0;
                A_HDR1: next_st.hdr[st.hsel].h1 = hw1;
                default: ;
            endcase
        end
        case (st.fsm)
            S_IDLE: begin
                if (start_go) begin
                    next_st.xid = pwdata[XID_W-1:0];
                    next_st.retried = 1'b0;
                    next_st.req = build_req(st.desc[pwdata[XID_W-1:0]],
                        st.desc[pwdata[XID_W-1:0]].w0.bus
                        ^ (st.desc[pwdata[XID_W-1:0]].w0.retry == RTY_ALTERNATE && st.alt[pwdata[XID_W-1:0]]),
                        pool_idx(st.hdr[st.desc[pwdata[XID_W-1:0]].w1.hdr_id]));
                    next_st.fsm = S_ISSUE;
                end
            end
            S_ISSUE: begin
                if (link_req_ready) begin
                    next_st.fsm = S_WAIT;
                end
            end
            S_WAIT: begin
                if (link_rsp_valid) begin
                    next_st.last_sw = link_rsp.sw1;
                    // one retry, same or other bus
                    if (rsp_err && cd.w0.retry != RTY_OFF && !st.retried) begin
                        next_st.retried = 1'b1;
                        next_st.req.bus = st.req.bus ^ (cd.w0.retry != RTY_SAME);
                        next_st.fsm = S_ISSUE;
                    end else begin
                        next_st.hdr[cd.w1.hdr_id].h1.cur_idx = next_idx(ch, rsp_err);
                        if (cd.w0.retry == RTY_ALTERNATE) begin
                            next_st.alt[st.xid] = !st.alt[st.xid];
                        end
                        next_st.evt = next_st.evt | {sxw, rsp_err, 1'b1};
                        next_st.host_event = irq_fire;
                        next_st.halted = next_st.halted | halt_fire;
                        next_st.gap_cnt = gap_cyc;
                        next_st.fsm = S_GAP;
                        if (srq_go) begin
                            next_st.req = '0;
                            next_st.req.cmd1 = cmd_word(link_rsp.sw1[15:11], 1'b1, SA_MODE_LO, MC_TX_VECTOR);
                            next_st.req.mode = 1'b1;
                            next_st.req.bus = st.req.bus;
                            next_st.req.expect_sw1 = 1'b1;
                            next_st.fsm = S_SRQ_ISSUE;
                        end
                    end
                end
            end
            S_SRQ_ISSUE: begin
                if (link_req_ready) begin
                    next_st.fsm = S_SRQ_WAIT;
                end
            end
            S_SRQ_WAIT: begin
                if (link_rsp_valid) begin
                    next_st.vector = link_rsp.data;
                    next_st.fsm = S_GAP;
                end
            end
            S_GAP: begin
                if (st.gap_cnt <= GAP_W'(1)) begin
                    next_st.fsm = S_IDLE;
                end else begin
                    next_st.gap_cnt = st.gap_cnt - GAP_W'(1);
                end
            end
            default: next_st.fsm = S_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pready = st.ack;
    assign prdata = st.prdata;
    assign pslverr = st.ack && st.perr;
    assign link_req_valid = st.fsm == S_ISSUE || st.fsm == S_SRQ_ISSUE;
    assign link_req = st.req;
    assign host_event = st.host_event;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pready_single_cycle: assert property (pready |=> !pready)
        else $error("pready held beyond one cycle");
    a_req_held_stable: assert property (link_req_valid && !link_req_ready |=> link_req_valid && $stable(link_req))
        else $error("link request changed before acceptance");
    a_halted_no_start: assert property ($past(st.halted) |-> !(st.fsm == S_ISSUE && $past(st.fsm) == S_IDLE))
        else $error("transfer started while halted");
    a_gap_min_wait: assert property (st.fsm == S_GAP && $past(st.fsm) == S_WAIT && !cd.w1.gap_mode
        |-> st.gap_cnt >= GAP_W'(MIN_GAP_CYC))
        else $error("gap shorter than minimum");
    a_gap_end_idle: assert property (st.fsm == S_GAP && st.gap_cnt <= GAP_W'(1) |=> st.fsm == S_IDLE)
        else $error("gap did not end on count");
    a_mode_flag_match: assert property (st.fsm == S_ISSUE && $past(st.fsm) == S_IDLE
        |-> link_req.mode == (is_mode(cd.w0.transmit_subaddress) && cd.w0.dir != DIR_BC_RT
                              || is_mode(cd.w0.receive_subaddress) && cd.w0.dir != DIR_RT_BC))
        else $error("mode flag disagrees with subaddress");
    a_vector_code: assert property (st.fsm == S_SRQ_ISSUE |-> link_req.cmd1[4:0] == MC_TX_VECTOR && link_req.mode)
        else $error("service request not vector mode code");
    a_sync_only_sync: assert property (link_req_valid && link_req.err_type != ERR_CMD_SYNC
        && link_req.err_type != ERR_DATA_SYNC |-> link_req.err_sync == '0)
        else $error("sync pattern on non-sync scheme");
    a_event_sets_eot: assert property (host_event |-> st.evt[0] && $past(st.fsm) == S_WAIT)
        else $error("host event without completion");
    a_index_in_queue: assert property ($past(st.fsm) == S_WAIT && st.fsm != S_ISSUE
        && $past(ch.h1.cur_idx) < qsize($past(ch)) |-> st.hdr[cd.w1.hdr_id].h1.cur_idx < qsize(ch))
        else $error("current index left the queue");

    c_plain_transfer: cover property (st.fsm == S_WAIT ##1 st.fsm == S_GAP);
    c_retry_taken: cover property (st.fsm == S_WAIT ##1 st.fsm == S_ISSUE);
    c_vector_request: cover property (st.fsm == S_SRQ_WAIT ##1 st.fsm == S_GAP);
    c_halt_reached: cover property ($rose(st.halted));
endmodule

// File: pkg/bcxd_pkg.sv
/*
 * Shared types and constants of the transfer-descriptor block: register
 * offsets, descriptor and buffer-header layouts, link request/answer carriers.
 * Assumes a 10 MHz pclk and a bus interface processor on the link side.
 */
package bcxd_pkg;
    localparam int NUM_XFER = 511;
    localparam int XID_W = 9;
    localparam int NUM_HDR = 64;
    localparam int HID_W = 6;
    localparam int BUF_W = 12;
    localparam int QIDX_W = 8;
    localparam int GAP_W = 20;
    localparam int CLK_HZ = 10_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int MIN_GAP_US = 11;
    localparam int MIN_GAP_CYC = MIN_GAP_US * CYC_PER_US;
    localparam logic [XID_W-1:0] LAST_XID = 9'h1FE;
    localparam int SRQ_BIT = 8;
    localparam int SW_CHECK_W = 11;
    localparam logic [4:0] SA_MODE_LO = 5'h00;
    localparam logic [4:0] SA_MODE_HI = 5'h1F;
    localparam logic [4:0] MC_TX_VECTOR = 5'h10;

    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_START = 8'h04;
    localparam logic [7:0] A_STATUS = 8'h08;
    localparam logic [7:0] A_DSEL = 8'h0C;
    localparam logic [7:0] A_DESC0 = 8'h10;
    localparam logic [7:0] A_DESC1 = 8'h14;
    localparam logic [7:0] A_DESC2 = 8'h18;
    localparam logic [7:0] A_HSEL = 8'h1C;
    localparam logic [7:0] A_HDR0 = 8'h20;
    localparam logic [7:0] A_HDR1 = 8'h24;
    localparam logic [7:0] A_LAST_SW = 8'h28;
    localparam logic [7:0] A_VECTOR = 8'h2C;

    typedef enum logic [1:0] {DIR_BC_RT = 2'h0, DIR_RT_BC = 2'h1, DIR_RT_RT = 2'h2, DIR_RSVD = 2'h3} bcxd_dir_t;
    typedef enum logic [1:0] {RTY_OFF = 2'h0, RTY_SAME = 2'h1, RTY_OTHER = 2'h2, RTY_ALTERNATE = 2'h3} bcxd_retry_t;
    typedef enum logic [1:0] {RSP_BASIC = 2'h0, RSP_NO_SW1 = 2'h1, RSP_NO_SW2 = 2'h2, RSP_RSVD = 2'h3} bcxd_rsp_t;
    typedef enum logic [1:0] {IRQ_NONE = 2'h0, IRQ_EOT = 2'h1, IRQ_ERR = 2'h2, IRQ_SXW = 2'h3} bcxd_irq_t;
    typedef enum logic [2:0] {
        HLT_NONE = 3'h0, HLT_EOT = 3'h1, HLT_ERR = 3'h2, HLT_SXW = 3'h3, HLT_ANY_INT = 3'h4
    } bcxd_halt_t;
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_CMD_SYNC = 4'h1;
    localparam logic [3:0] ERR_DATA_SYNC = 4'h2;
    localparam logic [3:0] ERR_LAST = 4'hE;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0, S_ISSUE = 3'h1, S_WAIT = 3'h2, S_SRQ_ISSUE = 3'h3, S_SRQ_WAIT = 3'h4, S_GAP = 3'h5
    } bcxd_fsm_t;

    typedef struct packed {
        bcxd_retry_t retry;
        bcxd_rsp_t rsp;
        logic [4:0] wcnt;
        logic [4:0] receive_subaddress;
        logic [4:0] transmit_subaddress;
        logic [4:0] receiving_terminal;
        logic [4:0] transmitting_terminal;
        logic bus;
        bcxd_dir_t dir;
    } bcxd_dw0_t;

    typedef struct packed {
        logic [7:0] rsvd;
        logic [5:0] err_sync;
        logic [3:0] err_type;
        logic [HID_W-1:0] hdr_id;
        logic gap_mode;
        logic [1:0] srq_act;
        bcxd_halt_t halt_sel;
        bcxd_irq_t irq_sel;
    } bcxd_dw1_t;

    typedef struct packed {
        logic [15:0] gap;
        logic [4:0] rsvd;
        logic [SW_CHECK_W-1:0] swxm;
    } bcxd_dw2_t;

    typedef struct packed {
        bcxd_dw2_t w2;
        bcxd_dw1_t w1;
        bcxd_dw0_t w0;
    } bcxd_desc_t;

    typedef struct packed {
        logic [14:0] rsvd;
        logic store_keep;
        logic queue_wraparound;
        logic [2:0] qsize_code;
        logic [BUF_W-1:0] first_buf;
    } bcxd_hw0_t;

    typedef struct packed {
        logic [17:0] rsvd;
        logic [5:0] buf_size;
        logic [QIDX_W-1:0] cur_idx;
    } bcxd_hw1_t;

    typedef struct packed {
        bcxd_hw1_t h1;
        bcxd_hw0_t h0;
    } bcxd_hdr_t;

    typedef struct packed {
        logic [6:0] rsvd0;
        logic [XID_W-1:0] last_xid;
        logic [10:0] rsvd1;
        logic halted;
        logic busy;
        logic sxw;
        logic err;
        logic eot;
    } bcxd_status_t;

    typedef struct packed {
        logic [15:0] cmd1;
        logic [15:0] cmd2;
        logic two_cmd;
        logic mode;
        logic bus;
        logic [BUF_W-1:0] buf_idx;
        logic [3:0] err_type;
        logic [5:0] err_sync;
        logic expect_sw1;
        logic expect_sw2;
    } bcxd_req_t;

    typedef struct packed {
        logic err;
        logic sw1_seen;
        logic sw2_seen;
        logic [15:0] sw1;
        logic [15:0] sw2;
        logic [15:0] data;
    } bcxd_rsp_word_t;

    typedef struct packed {
        bcxd_fsm_t fsm;
        bcxd_desc_t [NUM_XFER-1:0] desc;
        bcxd_hdr_t [NUM_HDR-1:0] hdr;
        logic [NUM_XFER-1:0] alt;
        logic srq_en;
        logic [XID_W-1:0] xid;
        logic [XID_W-1:0] dsel;
        logic [HID_W-1:0] hsel;
        logic retried;
        logic [2:0] evt;
        logic halted;
        logic host_event;
        logic [15:0] last_sw;
        logic [15:0] vector;
        logic [GAP_W-1:0] gap_cnt;
        bcxd_req_t req;
        logic ack;
        logic [31:0] prdata;
        logic perr;
    } bcxd_state_t;
endpackage

// File: tb/bcxd_link_model.sv
/* far-side link model: takes one request, answers after a delay.
   assumes the block's link ports on a shared pclk and presetn. */
`timescale 1ns/1ns
module bcxd_link_model
    import bcxd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic link_req_valid,
    input wire bcxd_req_t link_req,
    output logic link_req_ready,
    output logic link_rsp_valid,
    output bcxd_rsp_word_t link_rsp,
    input wire logic bad_rsp,
    input wire logic srq_flag,
    input wire logic [3:0] delay
);
    logic pend;
    logic [3:0] cnt;
    bcxd_req_t held;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_req_ready <= 1'b0;
            link_rsp_valid <= 1'b0;
            link_rsp <= '0;
            pend <= 1'b0;
            cnt <= 4'h0;
            held <= '0;
        end else begin
            link_rsp_valid <= 1'b0;
            link_req_ready <= link_req_valid && !pend && !link_req_ready;
            if (link_req_valid && link_req_ready) begin
                pend <= 1'b1;
                cnt <= delay;
                held <= link_req;
            end
            if (pend && cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end
            // answer whole, status presence as asked
            if (pend && cnt == 4'h0) begin
                pend <= 1'b0;
                link_rsp_valid <= 1'b1;
                link_rsp <= '{bad_rsp, held.expect_sw1, held.expect_sw2, {held.cmd1[15:11], 2'b00, srq_flag, 8'h00},
                    16'h0000, 16'h5A5A};
            end else begin
                link_rsp <= ~link_rsp;
            end
        end
    end
endmodule

// File: tb/tb_top.sv
/* bench for the transfer-descriptor block: register table, transfers, retry.
   assumes the link model on the far side and a 10 MHz pclk. */
`timescale 1ns/1ns
module tb_top
    import bcxd_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bad_rsp = 0, srq_flag = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, link_req_valid, link_req_ready, link_rsp_valid, host_event, er;
    bcxd_req_t link_req, seen;
    bcxd_rsp_word_t link_rsp;
    int num_errors = 0, checks_done = 0, cycles = 0, n_req = 0, n_evt = 0;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} bcxd_row_t;
    bcxd_row_t rows[8];
    always #50 pclk = ~pclk;
    bcxd_core bcxd_core_inst(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .link_req_valid(link_req_valid), .link_req_ready(link_req_ready), .link_req(link_req),
        .link_rsp_valid(link_rsp_valid), .link_rsp(link_rsp), .host_event(host_event));
    bcxd_link_model bcxd_link_model_inst(.pclk(pclk), .presetn(presetn), .link_req_valid(link_req_valid),
        .link_req(link_req), .link_req_ready(link_req_ready), .link_rsp_valid(link_rsp_valid),
        .link_rsp(link_rsp), .bad_rsp(bad_rsp), .srq_flag(srq_flag), .delay(4'h3));
    task give_verdict;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task check(input string what, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_done;
        repeat (300) begin
            apb(0, A_STATUS, 0);
            if (rd[3] === 1'b0) break;
        end
        check("idle", rd[3], 0);
    endtask
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (link_req_valid === 1'b1 && link_req_ready === 1'b1) begin
            n_req <= n_req + 1;
            seen <= link_req;
        end
        if (host_event === 1'b1) n_evt <= n_evt + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            give_verdict;
        end
    end
    initial begin
        rows = '{'{A_DSEL, 32'h1FE, 32'h1FE, 0}, '{A_DSEL, 32'h1FF, 32'h1FE, 1},
            '{A_DESC0, 32'h5A5A5A5A, 32'h5A5A5A5A, 0}, '{A_DESC1, 32'hAB123453, 32'h00123453, 0},
            '{A_DESC2, '1, 32'hFFFF07FF, 0}, '{A_HDR0, '1, 32'h0001FFFF, 0},
            '{A_HDR1, '1, 32'h00003FFF, 0}, '{8'h30, '1, 32'h0, 1}};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(1, rows[i].a, rows[i].w);
            check("wr_err", er, rows[i].e);
            apb(0, rows[i].a, 0);
            check("rd", rd, rows[i].r);
        end
        // one mode command, queue of 8 at 20
        apb(1, A_HSEL, 2);
        apb(1, A_HDR0, 32'h0000B014);
        apb(1, A_HDR1, 7);
        apb(1, A_DSEL, 3);
        apb(1, A_DESC0, 32'h017C0504);
        apb(1, A_DESC1, 32'h201);
        apb(1, A_DESC2, 0);
        apb(1, A_START, 3);
        wait_done;
        check("bus", seen.bus, 1);
        check("mode", seen.mode, 1);
        check("buf", seen.buf_idx, 27);
        check("cmd", seen.cmd1, 16'h2BE2);
        check("evt", n_evt, 1);
        check("eot", rd[2:0], 1);
        apb(0, A_HDR1, 0);
        check("wrap", rd[7:0], 0);
        // failed answer, one retry, queue advances
        bad_rsp <= 1'b1;
        apb(1, A_DESC0, 32'h417C0504);
        apb(1, A_START, 3);
        wait_done;
        check("retry", n_req, 3);
        check("err", rd[1], 1);
        apb(0, A_HDR1, 0);
        check("next", rd[7:0], 1);
        // service request, vector word, halt on end
        bad_rsp <= 1'b0;
        srq_flag <= 1'b1;
        apb(1, A_CTRL, 1);
        apb(1, A_DESC1, 32'h245);
        apb(1, A_DESC2, 32'h100);
        apb(1, A_START, 3);
        wait_done;
        check("sxw", rd[2], 1);
        check("halt", rd[4], 1);
        check("srq", n_req, 5);
        apb(0, A_VECTOR, 0);
        check("vec", rd, 32'h5A5A);
        apb(1, A_START, 3);
        apb(0, A_STATUS, 0);
        check("hold", n_req, 5);
        check("still", rd[3], 0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, A_DSEL, 0);
        check("rst", rd, 0);
        give_verdict;
    end
endmodule
